// ===== hdl/sbsp_pkg.sv
// Shared constants and carrier types of the synchronous burst memory port
package sbsp_pkg;
  localparam int ADDR_W      = 19;
  localparam int LANES       = 4;
  localparam int LANE_W      = 9;
  localparam int DATA_W      = LANES * LANE_W;
  localparam int BURST_W     = 2;
  localparam int BUF_DEPTH   = 2;
  localparam logic [BURST_W-1:0] CNT_RESET = 2'h0;
  localparam logic [BURST_W-1:0] CNT_STEP  = 2'h1;
  localparam logic [LANES-1:0]   LANES_ALL  = 4'hf;
  localparam logic [LANES-1:0]   LANES_NONE = 4'h0;
  localparam logic ORDER_LINEAR      = 1'b0;
  localparam logic ORDER_INTERLEAVED = 1'b1;
  localparam logic ORDER_RESET       = ORDER_INTERLEAVED;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lanes;
    logic [DATA_W-1:0] data;
  } sbsp_wr_t;

  localparam int WR_W = $bits(sbsp_wr_t);
endpackage

// ===== hdl/sbsp_mem.sv
// Lane-masked storage array with one write port and a registered read port
`timescale 1ns/1ns
module sbsp_mem import sbsp_pkg::*; #(
  parameter int AW = ADDR_W,
  parameter int NL = LANES,
  parameter int LW = LANE_W
) (
  input  wire logic             mclk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [NL-1:0]    wr_lanes,
  input  wire logic [NL*LW-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [NL*LW-1:0] rd_data
);
  logic [NL*LW-1:0] store [0:(1<<AW)-1];

  // One process masks every lane, so the array keeps a single driver
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      for (int g = 0; g < NL; g++) begin
        if (wr_lanes[g]) begin
          store[wr_addr][g*LW +: LW] <= wr_data[g*LW +: LW];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rd_en) begin
      rd_data <= store[rd_addr];
    end
  end
endmodule

// ===== hdl/sbsp_pair_buf.sv
// Two-entry valid/ready buffer for write words on their way to the array
`timescale 1ns/1ns
module sbsp_pair_buf import sbsp_pkg::*; #(
  parameter int W = WR_W
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  logic         v0, v1, space;
  logic [W-1:0] d0, d1;
  logic         next_v0, next_v1, next_space;
  logic [W-1:0] next_d0, next_d1;

  always_comb begin
    next_v0 = v0;
    next_v1 = v1;
    next_d0 = d0;
    next_d1 = d1;
    if (v0 && out_ready) begin
      next_v0 = v1;
      next_d0 = d1;
      next_v1 = 1'b0;
    end
    if (in_valid && space) begin
      if (!next_v0) begin
        next_v0 = 1'b1;
        next_d0 = in_data;
      end else begin
        next_v1 = 1'b1;
        next_d1 = in_data;
      end
    end
    next_space = !next_v1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      v0    <= 1'b0;
      v1    <= 1'b0;
      space <= 1'b1;
      d0    <= '0;
      d1    <= '0;
    end else begin
      v0    <= next_v0;
      v1    <= next_v1;
      space <= next_space;
      d0    <= next_d0;
      d1    <= next_d1;
    end
  end

  assign in_ready  = space;
  assign out_valid = v0;
  assign out_data  = d0;
endmodule

// ===== hdl/sbsp_port.sv
// Synchronous flow-through burst memory port: address, burst, select and write control
// Behaviour
// - Address captured only when either address strobe low and all three enables active.
// - Two low address bits set the burst start; the 2-bit burst counter restarts at zero.
// - Lane written when its select and the byte write gate are both low.
// - Global write low writes all lanes, ignoring lane selects and gate.
// - Burst counter increments on edges where burst step is sampled low while selected and no new address loads.
// - First enable active low; while high the processor strobe is ignored.
// - Second enable active high; combines with the others to select.
// - Third enable active low; combines with the others to select.
// - Enables evaluated only on new-address cycles, ignored during burst advance.
// - Output enable low drives data pins; high releases them as inputs.
// - First read clock after deselection keeps data pins undriven.
// - Burst step low within a burst moves to the next burst address.
// - Both strobes low on one edge with first enable low: only the processor strobe acts.
// - Order strap low selects linear, high interleaved; static in operation.
// - Data pins released during write data and while deselected.
// - Driven data is that of the location addressed at the previous edge.
`timescale 1ns/1ns
module sbsp_port import sbsp_pkg::*; #(
  parameter int AW = ADDR_W
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [AW-1:0]     addr,
  input  wire logic              proc_addr_strobe_n,
  input  wire logic              ctrl_addr_strobe_n,
  input  wire logic              burst_step_n,
  input  wire logic              byte_write_gate_n,
  input  wire logic [LANES-1:0]  lane_write_select_n,
  input  wire logic              all_bytes_write_n,
  input  wire logic              select_first_n,
  input  wire logic              select_second_hi,
  input  wire logic              select_third_n,
  input  wire logic              out_enable_n,
  input  wire logic              burst_order_strap,
  input  wire logic [DATA_W-1:0] data_pins_i,
  output logic      [DATA_W-1:0] data_pins_o,
  output logic                   data_pins_oe,
  output logic                   write_ready
);
  // State
  logic               selected;
  logic [AW-1:0]      base;
  logic [BURST_W-1:0] count;
  logic               burst_order;
  logic               strap_done;
  logic               strap_s1, strap_s2;
  // Age flags: the order register follows the second stage until the pin has crossed both stages, then holds
  logic               strap_v1, strap_v2;
  logic               oe_n_s1, oe_n_s2;
  logic               drive;
  logic               next_selected;
  logic [AW-1:0]      next_base;
  logic [BURST_W-1:0] next_count;
  logic               next_burst_order;
  logic               next_strap_done;
  logic               next_drive;

  // Decode
  logic               proc_go, ctrl_go, load, enables_ok;
  logic               write_req, do_write, do_read, buf_pop;
  logic [LANES-1:0]   lane_mask;
  logic [AW-1:0]      cur_addr;
  sbsp_wr_t           wr_word, buf_word;
  logic               buf_valid;

  function automatic logic [BURST_W-1:0] burst_low(
    input logic               order,
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] cnt
  );
    if (order == ORDER_INTERLEAVED) begin
      burst_low = start ^ cnt;
    end else begin
      burst_low = start + cnt;
    end
  endfunction

  always_comb begin
    // processor strobe needs first enable; it wins over controller
    proc_go    = !proc_addr_strobe_n && !select_first_n;
    ctrl_go    = !ctrl_addr_strobe_n && !proc_go;
    load       = proc_go || ctrl_go;
    // all three enables must be active
    enables_ok = !select_first_n && select_second_hi && !select_third_n;
    // enables only matter when a new address is loaded
    next_selected = load ? enables_ok : selected;
    next_base     = (load && enables_ok) ? addr : base;
    if (load) begin
      next_count = CNT_RESET;
    end else if (selected && !burst_step_n) begin
      next_count = count + CNT_STEP;
    end else begin
      next_count = count;
    end
    cur_addr = {next_base[AW-1:BURST_W],
                burst_low(burst_order, next_base[BURST_W-1:0], next_count)};
    if (!all_bytes_write_n) begin
      lane_mask = LANES_ALL;
    // lane select qualified by the byte write gate
    end else if (!byte_write_gate_n) begin
      lane_mask = ~lane_write_select_n;
    end else begin
      lane_mask = LANES_NONE;
    end
    write_req = lane_mask != LANES_NONE;
    // A processor-strobe cycle is never a write; writes follow on later edges
    do_write  = next_selected && !proc_go && write_req;
    do_read   = next_selected && !do_write;
    // drive only on reads past the first clock out of deselect
    next_drive = do_read && selected && !oe_n_s2;
  end

  always_comb begin
    // strap caught once both synchroniser stages hold pin data, then held
    next_strap_done  = strap_v2;
    next_burst_order = strap_done ? burst_order : strap_s2;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      selected    <= 1'b0;
      base        <= '0;
      count       <= CNT_RESET;
      drive       <= 1'b0;
      burst_order <= ORDER_RESET;
      strap_done  <= 1'b0;
      strap_s1    <= ORDER_RESET;
      strap_s2    <= ORDER_RESET;
      strap_v1    <= 1'b0;
      strap_v2    <= 1'b0;
      oe_n_s1     <= 1'b1;
      oe_n_s2     <= 1'b1;
    end else begin
      selected    <= next_selected;
      base        <= next_base;
      count       <= next_count;
      drive       <= next_drive;
      burst_order <= next_burst_order;
      strap_done  <= next_strap_done;
      strap_s1    <= burst_order_strap;
      strap_s2    <= strap_s1;
      strap_v1    <= 1'b1;
      strap_v2    <= strap_v1;
      oe_n_s1     <= out_enable_n;
      oe_n_s2     <= oe_n_s1;
    end
  end

  // Writes queue so a read on the array port never drops a write word.
  // Limitation: a read of a word still queued returns the older contents.
  always_comb begin
    wr_word.addr  = cur_addr;
    wr_word.lanes = lane_mask;
    wr_word.data  = data_pins_i;
  end

  assign buf_pop = buf_valid && !do_read;

  sbsp_pair_buf #(.W(WR_W)) u_buf (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (do_write),
    .in_ready  (write_ready),
    .in_data   (wr_word),
    .out_valid (buf_valid),
    .out_ready (!do_read),
    .out_data  (buf_word)
  );

  // flow-through read of the address taken at this edge
  sbsp_mem #(.AW(AW), .NL(LANES), .LW(LANE_W)) u_mem (
    .mclk     (mclk),
    .wr_en    (buf_pop),
    .wr_addr  (buf_word.addr),
    .wr_lanes (buf_word.lanes),
    .wr_data  (buf_word.data),
    .rd_en    (do_read),
    .rd_addr  (cur_addr),
    .rd_data  (data_pins_o)
  );

  assign data_pins_oe = drive;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_ADDR_CAPTURE: assert property (
    (!proc_addr_strobe_n && enables_ok) |=> (base == $past(addr) && selected))
    else $error("address not captured on selected strobe");
  AST_COUNT_LOAD: assert property (
    load |=> (count == CNT_RESET))
    else $error("burst counter not restarted on strobe");
  AST_LANE_WRITE: assert property (
    (do_write && all_bytes_write_n && !byte_write_gate_n)
      |-> (wr_word.lanes == ~lane_write_select_n))
    else $error("lane mask does not follow lane selects");
  AST_GLOBAL_WRITE: assert property (
    (do_write && !all_bytes_write_n) |-> (wr_word.lanes == LANES_ALL))
    else $error("global write missed a lane");
  AST_BURST_STEP: assert property (
    (selected && !load && !burst_step_n) |=> (count == $past(count) + CNT_STEP))
    else $error("burst counter did not advance");
  AST_FIRST_GATES_PROC: assert property (
    (select_first_n && !proc_addr_strobe_n && ctrl_addr_strobe_n)
      |=> ($stable(base) && $stable(selected)))
    else $error("processor strobe acted with first enable high");
  AST_DESELECT: assert property (
    (load && (!select_second_hi || select_third_n)) |=> !selected)
    else $error("strobe with inactive enable left device selected");
  AST_ENABLES_IGNORED: assert property (
    (!load) |=> $stable(selected))
    else $error("selection changed without a new address");
  AST_OE_RELEASE: assert property (
    out_enable_n [*3] |=> !data_pins_oe)
    else $error("data pins driven with output enable high");
  AST_FIRST_READ_MASK: assert property (
    (!selected && do_read) |=> !data_pins_oe)
    else $error("data driven on first clock out of deselect");
  AST_PROC_WINS: assert property (
    (proc_go && !ctrl_addr_strobe_n) |-> !do_write)
    else $error("controller strobe acted beside processor strobe");
  AST_STRAP_HELD: assert property (
    strap_done |=> $stable(burst_order))
    else $error("burst order changed in operation");
  AST_HIZ_WRITE: assert property (
    (do_write || !next_selected) |=> !data_pins_oe)
    else $error("data pins driven during write or deselect");

  AST_SELECT_ON_LOAD: assert property (
    (load && enables_ok) |=> selected)
    else $error("enabled strobe left device deselected");

  AST_CTRL_CAPTURE: assert property (
    (!ctrl_addr_strobe_n && enables_ok) |=> (base == $past(addr)))
    else $error("address not captured on controller strobe");

  AST_START_BITS: assert property (
    (load && enables_ok) |-> (cur_addr == addr))
    else $error("burst did not start at the presented address");

  AST_GATE_CLOSED: assert property (
    (all_bytes_write_n && byte_write_gate_n) |-> !do_write)
    else $error("write without global write or byte write gate");

  AST_LANE_SKIP: assert property (
    (do_write && all_bytes_write_n) |-> ((wr_word.lanes & lane_write_select_n) == LANES_NONE))
    else $error("lane written with its select high");

  AST_STEP_HOLD: assert property (
    (!load && burst_step_n) |=> $stable(count))
    else $error("burst counter moved without burst step");

  AST_FIRST_DESELECT: assert property (
    (!ctrl_addr_strobe_n && select_first_n) |=> !selected)
    else $error("strobe with first enable high left device selected");

  AST_THIRD_DESELECT: assert property (
    (load && select_third_n) |=> !selected)
    else $error("strobe with third enable high left device selected");

  AST_BURST_KEEPS_SELECT: assert property (
    (selected && !load) |=> selected)
    else $error("device deselected inside a burst");

  AST_OE_DRIVE: assert property (
    (!out_enable_n) [*3] ##0 (do_read && selected) |=> data_pins_oe)
    else $error("read not driven with output enable low");

  AST_HIZ_DESELECTED: assert property (
    !selected |-> !data_pins_oe)
    else $error("data pins driven while deselected");

  AST_PROC_LOAD: assert property (
    (proc_go && !ctrl_addr_strobe_n && enables_ok) |=> (selected && count == CNT_RESET))
    else $error("processor strobe not taken beside controller strobe");

  AST_ORDER_TAKEN: assert property (
    $rose(strap_done) |-> (burst_order == $past(strap_s2)))
    else $error("burst order not taken from the strap");

  AST_GROUP_WRAP: assert property (
    (selected && !load) |-> (cur_addr[AW-1:BURST_W] == base[AW-1:BURST_W]))
    else $error("burst left its group of four");

  AST_COUNT_WRAP: assert property (
    (selected && !load && !burst_step_n && count == 2'h3) |=> (count == CNT_RESET))
    else $error("burst counter did not wrap");

  COV_FULL_BURST: cover property (
    load && enables_ok ##1 (!burst_step_n && !write_req) [*3]);
  COV_GLOBAL_WRITE: cover property (do_write && !all_bytes_write_n);
  COV_BUFFER_FULL: cover property (!write_ready);
  COV_DRIVEN_READ: cover property (data_pins_oe);
  COV_BOTH_STROBES: cover property (proc_go && !ctrl_addr_strobe_n);
endmodule

// ===== dv/sbsp_bus_side.sv
// Controller side of the shared data pins, resolving who drives them
`timescale 1ns/1ns
module sbsp_bus_side import sbsp_pkg::*; (
  input  wire logic              mclk,
  input  wire logic              drive_en,
  input  wire logic [DATA_W-1:0] drive_data,
  input  wire logic [DATA_W-1:0] data_pins_o,
  input  wire logic              data_pins_oe,
  output logic      [DATA_W-1:0] data_pins_i
);
  logic [DATA_W-1:0] last = '0;

  // write data whenever enabled, memory data only while it drives
  always_comb begin
    // Write data wins while the registered memory enable still lingers for an edge
    if (drive_en) data_pins_i = drive_data;
    else if (data_pins_oe) data_pins_i = data_pins_o;
    else data_pins_i = ~last;
  end

  // Floating pins must not look like stable data
  always @(posedge mclk) begin
    last <= data_pins_i;
  end
endmodule

// ===== dv/test_sync_burst_sram_port.sv
// Self-checking bench for the burst memory port
`timescale 1ns/1ns
module test_sync_burst_sram_port import sbsp_pkg::*; ;
  logic              mclk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic              proc_addr_strobe_n = 1'b1;
  logic              ctrl_addr_strobe_n = 1'b1;
  logic              burst_step_n = 1'b1;
  logic              byte_write_gate_n = 1'b1;
  logic [LANES-1:0]  lane_write_select_n = LANES_ALL;
  logic              all_bytes_write_n = 1'b1;
  logic              select_first_n = 1'b1;
  logic              select_second_hi = 1'b0;
  logic              select_third_n = 1'b1;
  logic              out_enable_n = 1'b0;
  logic              burst_order_strap = 1'b0;
  logic              drive_en = 1'b0;
  logic [DATA_W-1:0] drive_data = '0;
  logic [DATA_W-1:0] data_pins_i;
  logic [DATA_W-1:0] data_pins_o;
  logic              data_pins_oe;
  logic              write_ready;
  logic [DATA_W-1:0] mem [int];
  int                n_fail = 0;
  int                samples_checked = 0;
  int                seed;
  logic [ADDR_W-1:0] base;

  sbsp_port DUT (.mclk, .rst_n, .addr, .proc_addr_strobe_n, .ctrl_addr_strobe_n,
    .burst_step_n, .byte_write_gate_n, .lane_write_select_n, .all_bytes_write_n,
    .select_first_n, .select_second_hi, .select_third_n, .out_enable_n,
    .burst_order_strap, .data_pins_i, .data_pins_o, .data_pins_oe, .write_ready);
  sbsp_bus_side host (.mclk, .drive_en, .drive_data, .data_pins_o, .data_pins_oe,
    .data_pins_i);

  always #5 mclk = ~mclk;

  task automatic complete_run;
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #900000;
    $display("[FAIL] %0t watchdog", $time);
    n_fail++;
    complete_run;
  end

  task automatic chk(input logic [DATA_W-1:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  // Inputs always change 1 ns after the sampling edge
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask

  function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] o, d, logic [LANES-1:0] en);
    for (int g = 0; g < LANES; g++) if (en[g]) o[g*LANE_W +: LANE_W] = d[g*LANE_W +: LANE_W];
    return o;
  endfunction

  function automatic logic [ADDR_W-1:0] baddr(logic [ADDR_W-1:0] a, logic [1:0] n, logic o);
    baddr = a;
    baddr[1:0] = o ? (a[1:0] ^ n) : (a[1:0] + n);
  endfunction

  task automatic idle(input int n);
    logic [2:0] s;
    s = 3'($random(seed));
    if (s == 3'b010) s = 3'b000;
    {select_first_n, select_second_hi, select_third_n} = s;
    ctrl_addr_strobe_n = 1'b0;
    tick;
    ctrl_addr_strobe_n = 1'b1;
    repeat (n) begin
      {select_first_n, select_second_hi, select_third_n} = 3'($random(seed));
      tick;
      chk(data_pins_oe, 1'b0, "driven while deselected");
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln, input logic gt, gw);
    logic [DATA_W-1:0] d;
    int                k;
    logic              hit;
    d = DATA_W'({$random(seed), $random(seed)});
    // A strobe with no lane enabled is a read of the still selected device
    hit = !gw || (!gt && ln != LANES_ALL);
    for (k = 0; k < 20 && write_ready !== 1'b1; k++) tick;
    if (k == 20) begin
      n_fail++;
      $display("[FAIL] %0t write buffer stuck", $time);
      complete_run;
    end
    {select_first_n, select_second_hi, select_third_n} = 3'b010;
    ctrl_addr_strobe_n = 1'b0;
    addr = a;
    lane_write_select_n = ln;
    byte_write_gate_n = gt;
    all_bytes_write_n = gw;
    drive_en = 1'b1;
    drive_data = d;
    tick;
    chk(data_pins_oe, !hit, "output enable wrong on write edge");
    if (!mem.exists(a)) mem[a] = d;
    mem[a] = merge(mem[a], d, !gw ? LANES_ALL : (gt ? LANES_NONE : ~ln));
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic ord);
    logic [1:0] n;
    n = 2'h0;
    {select_first_n, select_second_hi, select_third_n} = 3'b010;
    proc_addr_strobe_n = 1'b0;
    addr = a;
    tick;
    chk(data_pins_o, mem[a], "load read data");
    chk(data_pins_oe, 1'b0, "first read after deselect");
    for (int i = 0; i < 8; i++) begin
      burst_step_n = 1'($random(seed));
      proc_addr_strobe_n = 1'($random(seed));
      // Processor strobe only while first enable high, so it must be ignored
      {select_first_n, select_second_hi, select_third_n} =
        3'($random(seed)) | {~proc_addr_strobe_n, 2'b00};
      addr = ADDR_W'($random(seed));
      tick;
      n = n + 2'(!burst_step_n);
      chk(data_pins_o, mem[baddr(a, n, ord)], "burst data");
      if (i > 0) chk(data_pins_oe, 1'b1, "not driven with output enable low");
    end
    proc_addr_strobe_n = 1'b1;
    burst_step_n = 1'b1;
    out_enable_n = 1'b1;
    repeat (3) tick;
    chk(data_pins_oe, 1'b0, "driven with output enable high");
    chk(data_pins_o, mem[baddr(a, n, ord)], "held burst data");
    out_enable_n = 1'b0;
  endtask

  initial begin
    seed = 32'h45b0b3db;
    for (int ph = 0; ph < 2; ph++) begin
      burst_order_strap = ph[0];
      rst_n = 1'b0;
      repeat (4) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      idle(4);
      base = ADDR_W'($random(seed)) & ~ADDR_W'(3);
      for (int k = 0; k < 4; k++) wr(base + 2'(k), 4'($random(seed)), 1'($random(seed)), 1'b0);
      for (int k = 0; k < 6; k++) wr(base + 2'($random(seed)), 4'($random(seed)), 1'b0, 1'b1);
      wr(base + 2'h1, 4'h0, 1'b1, 1'b1);
      {all_bytes_write_n, byte_write_gate_n, drive_en} = 3'b110;
      idle(4);
      for (int k = 0; k < 4; k++) begin
        rd(base + 2'(k), ph[0]);
        idle(2);
      end
      // Both strobes with global write low must act as a plain read
      {select_first_n, select_second_hi, select_third_n} = 3'b010;
      {proc_addr_strobe_n, ctrl_addr_strobe_n, all_bytes_write_n, drive_en} = 4'h1;
      addr = base;
      drive_data = ~mem[base];
      tick;
      chk(data_pins_o, mem[base], "both strobes read");
      {proc_addr_strobe_n, all_bytes_write_n, drive_en} = 3'b110;
      idle(4);
      rd(base, ph[0]);
      idle(2);
      $display("phase %0d done", ph);
    end
    complete_run;
  end
endmodule
